// *** bbfx_exec_unit.sv ***
/*
 * bbfx_exec_unit: executes branch, io bit, shift, flag, bit transfer and move operations
 * on its own program counter, status flags, general registers and io registers.
 * assumes: an apb master on pclk; pready follows ce, so a low ce stalls the bus too.
 */
`timescale 1ns/1ps

module bbfx_exec_unit
  import bbfx_pkg::*;
#(
  parameter int PC_W = 16,
  parameter int K_W = 7,
  parameter int NREG = 32,
  parameter int NIO = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0] gpr [NREG];
  logic [7:0] io_reg [NIO];
  logic [7:0] status_flags_register;
  logic [PC_W-1:0] pc;
  bbfx_state_t state;
  bbfx_op_t op;
  logic [4:0] rd_idx;
  logic [4:0] rr_idx;
  logic [2:0] bit_idx;
  logic [K_W-1:0] k_off;
  logic last_taken;
  logic [1:0] last_cycles;

  logic acc;
  logic wr_en;
  logic busy;
  logic addr_ok;
  logic [31:0] next_rdata;
  logic [4:0] page;
  logic [4:0] widx;

  logic taken;
  logic is_branch;
  logic two_cycle;
  logic finish;
  logic [7:0] rd_val;
  logic [7:0] rr_val;
  logic [7:0] io_val;
  logic [7:0] next_status_flags_register;
  logic [7:0] res;
  logic res_we;
  logic [7:0] next_io;
  logic io_we;
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] k_ext;

  // ****************************************
  // apb decode
  // ****************************************
  assign acc = psel && penable && ce;
  assign wr_en = acc && pwrite && !busy && (pstrb != 4'h0);
  assign busy = (state != BBFX_ST_IDLE);
  assign pready = ce;
  assign page = paddr[11:7];
  assign widx = paddr[6:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && ((paddr == BBFX_CMD_ADDR) || (paddr == BBFX_PC_ADDR)
                   || (paddr == BBFX_STATUS_FLAGS_REGISTER_ADDR) || (paddr == BBFX_STAT_ADDR)
                   || ((page == BBFX_GPR_PAGE) && (32'(widx) < NREG))
                   || ((page == BBFX_IO_PAGE) && (32'(widx) < NIO)));
  assign pslverr = acc && !addr_ok;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (paddr == BBFX_PC_ADDR) begin
      next_rdata[PC_W-1:0] = pc;
    end else if (paddr == BBFX_STATUS_FLAGS_REGISTER_ADDR) begin
      next_rdata[7:0] = status_flags_register;
    end else if (paddr == BBFX_STAT_ADDR) begin
      next_rdata[3:0] = {last_cycles, last_taken, busy};
    end else if (addr_ok && (page == BBFX_GPR_PAGE)) begin
      next_rdata[7:0] = gpr[widx];
    end else if (addr_ok && (page == BBFX_IO_PAGE)) begin
      next_rdata[7:0] = io_reg[widx];
    end
  end

  // read data caught in the setup cycle, stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      prdata <= next_rdata;
    end
  end

  // ****************************************
  // condition and operand logic
  // ****************************************
  assign rd_val = gpr[rd_idx];
  assign rr_val = gpr[rr_idx];
  assign io_val = io_reg[rr_idx];
  assign k_ext = PC_W'(signed'(k_off));

  always_comb begin
    is_branch = 1'b1;
    taken = 1'b0;
    case (op)
      BBFX_OP_BRANCH_ZERO_CLEAR: taken = !status_flags_register[BBFX_FZ];
      BBFX_OP_BRANCH_NEGATIVE: taken = status_flags_register[BBFX_FN];
      BBFX_OP_BRANCH_NONNEGATIVE: taken = !status_flags_register[BBFX_FN];
      BBFX_OP_BRANCH_CARRY_ONE, BBFX_OP_BRANCH_UNSIGNED_LT: begin
        taken = status_flags_register[BBFX_FC];
      end
      BBFX_OP_BRANCH_CARRY_ZERO, BBFX_OP_BRANCH_UNSIGNED_GE: begin
        taken = !status_flags_register[BBFX_FC];
      end
      BBFX_OP_BRANCH_SIGNED_GE: begin
        taken = !(status_flags_register[BBFX_FN] ^ status_flags_register[BBFX_FV]);
      end
      BBFX_OP_BRANCH_SIGNED_LT: begin
        taken = status_flags_register[BBFX_FN] ^ status_flags_register[BBFX_FV];
      end
      BBFX_OP_BRANCH_HALFCARRY_ONE: taken = status_flags_register[BBFX_FH];
      BBFX_OP_BRANCH_HALFCARRY_ZERO: taken = !status_flags_register[BBFX_FH];
      BBFX_OP_BRANCH_OVERFLOW_ONE: taken = status_flags_register[BBFX_FV];
      BBFX_OP_BRANCH_OVERFLOW_ZERO: taken = !status_flags_register[BBFX_FV];
      BBFX_OP_BRANCH_TBIT_ONE: taken = status_flags_register[BBFX_FT];
      BBFX_OP_BRANCH_TBIT_ZERO: taken = !status_flags_register[BBFX_FT];
      BBFX_OP_BRANCH_IRQ_ON: taken = status_flags_register[BBFX_FI];
      BBFX_OP_BRANCH_IRQ_OFF: taken = !status_flags_register[BBFX_FI];
      default: is_branch = 1'b0;
    endcase
  end

  assign two_cycle = (is_branch && taken) || (op == BBFX_OP_IO_BIT_FORCE_HIGH)
                     || (op == BBFX_OP_IO_BIT_FORCE_LOW);
  assign finish = ((state == BBFX_ST_EXEC) && !two_cycle) || (state == BBFX_ST_EXEC2);
  // relative target shared by every branch form
  assign next_pc = (is_branch && taken) ? (pc + k_ext + PC_W'(1)) : (pc + PC_W'(1));

  always_comb begin
    next_status_flags_register = status_flags_register;
    res = rd_val;
    res_we = 1'b0;
    next_io = io_val;
    io_we = 1'b0;
    case (op)
      BBFX_OP_IO_BIT_FORCE_HIGH: begin
        next_io[bit_idx] = 1'b1;
        io_we = 1'b1;
      end
      BBFX_OP_IO_BIT_FORCE_LOW: begin
        next_io[bit_idx] = 1'b0;
        io_we = 1'b1;
      end
      BBFX_OP_SHIFT_UP_LOGICAL: begin
        res = {rd_val[6:0], 1'b0};
        next_status_flags_register[BBFX_FC] = rd_val[7];
        res_we = 1'b1;
      end
      BBFX_OP_SHIFT_DOWN_LOGICAL: begin
        res = {1'b0, rd_val[7:1]};
        next_status_flags_register[BBFX_FC] = rd_val[0];
        res_we = 1'b1;
      end
      BBFX_OP_ROTATE_DOWN_VIA_CARRY: begin
        res = {status_flags_register[BBFX_FC], rd_val[7:1]};
        next_status_flags_register[BBFX_FC] = rd_val[0];
        res_we = 1'b1;
      end
      BBFX_OP_SHIFT_DOWN_ARITH: begin
        res = {rd_val[7], rd_val[7:1]};
        next_status_flags_register[BBFX_FC] = rd_val[0];
        res_we = 1'b1;
      end
      BBFX_OP_NIBBLE_SWAP: begin
        res = {rd_val[3:0], rd_val[7:4]};
        res_we = 1'b1;
      end
      BBFX_OP_FLAG_FORCE_HIGH_INDEXED: next_status_flags_register[bit_idx] = 1'b1;
      BBFX_OP_FLAG_FORCE_LOW_INDEXED: next_status_flags_register[bit_idx] = 1'b0;
      BBFX_OP_INTERRUPTS_ON: next_status_flags_register[BBFX_FI] = 1'b1;
      BBFX_OP_INTERRUPTS_OFF: next_status_flags_register[BBFX_FI] = 1'b0;
      BBFX_OP_BIT_TO_TRANSFER_FLAG: next_status_flags_register[BBFX_FT] = rr_val[bit_idx];
      BBFX_OP_TRANSFER_FLAG_TO_BIT: begin
        res[bit_idx] = status_flags_register[BBFX_FT];
        res_we = 1'b1;
      end
      BBFX_OP_REGISTER_COPY: begin
        res = rr_val;
        res_we = 1'b1;
      end
      default: begin
        next_status_flags_register = status_flags_register;
      end
    endcase
    // shift family: z, n and v from the result and new carry
    if ((op == BBFX_OP_SHIFT_UP_LOGICAL) || (op == BBFX_OP_SHIFT_DOWN_LOGICAL)
        || (op == BBFX_OP_ROTATE_DOWN_VIA_CARRY) || (op == BBFX_OP_SHIFT_DOWN_ARITH)) begin
      next_status_flags_register[BBFX_FZ] = (res == 8'h00);
      next_status_flags_register[BBFX_FN] = res[7];
      next_status_flags_register[BBFX_FV] = res[7] ^ next_status_flags_register[BBFX_FC];
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= BBFX_ST_IDLE;
      op <= BBFX_OP_NOP;
      rd_idx <= 5'h00;
      rr_idx <= 5'h00;
      bit_idx <= 3'h0;
      k_off <= '0;
    end else if (ce) begin
      case (state)
        BBFX_ST_IDLE: begin
          if (wr_en && (paddr == BBFX_CMD_ADDR)) begin
            op <= bbfx_op_t'(pwdata[BBFX_OP_LSB +: 5]);
            rd_idx <= pwdata[BBFX_RD_LSB +: 5];
            rr_idx <= pwdata[BBFX_RR_LSB +: 5];
            bit_idx <= pwdata[BBFX_BIT_LSB +: 3];
            k_off <= pwdata[BBFX_K_LSB +: K_W];
            state <= BBFX_ST_EXEC;
          end
        end
        BBFX_ST_EXEC: state <= two_cycle ? BBFX_ST_EXEC2 : BBFX_ST_IDLE;
        BBFX_ST_EXEC2: state <= BBFX_ST_IDLE;
        default: state <= BBFX_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_taken <= 1'b0;
      last_cycles <= 2'b00;
    end else if (ce && (state == BBFX_ST_EXEC)) begin
      last_taken <= is_branch && taken;
      last_cycles <= two_cycle ? 2'(BBFX_BRANCH_TAKEN_CYC) : 2'(BBFX_SINGLE_CYC);
    end
  end

  // ****************************************
  // architectural state updates
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= BBFX_PC_RST;
    end else if (ce) begin
      if (finish) begin
        pc <= next_pc;
      end else if (wr_en && (paddr == BBFX_PC_ADDR)) begin
        pc <= pwdata[PC_W-1:0];
      end
    end
  end

  // branches, io bit ops, moves and swap leave the flags as they are
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags_register <= BBFX_STATUS_FLAGS_REGISTER_RST;
    end else if (ce) begin
      if (finish) begin
        status_flags_register <= next_status_flags_register;
      end else if (wr_en && (paddr == BBFX_STATUS_FLAGS_REGISTER_ADDR)) begin
        status_flags_register <= pwdata[7:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_gpr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gpr[gi] <= BBFX_REG_RST;
        end else if (ce) begin
          if (finish && res_we && (rd_idx == 5'(gi))) begin
            gpr[gi] <= res;
          end else if (wr_en && (page == BBFX_GPR_PAGE) && (widx == 5'(gi)) && pstrb[0]) begin
            gpr[gi] <= pwdata[7:0];
          end
        end
      end
    end
    for (gi = 0; gi < NIO; gi++) begin : g_io
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          io_reg[gi] <= BBFX_REG_RST;
        end else if (ce) begin
          if (finish && io_we && (rr_idx == 5'(gi))) begin
            io_reg[gi] <= next_io;
          end else if (wr_en && (page == BBFX_IO_PAGE) && (widx == 5'(gi)) && pstrb[0]) begin
            io_reg[gi] <= pwdata[7:0];
          end
        end
      end
    end
  endgenerate

endmodule : bbfx_exec_unit

// *** bbfx_exec_unit_props.sv ***
/* bbfx_exec_unit_chk: port-level assertions for bbfx_exec_unit.
   assumes: software polls stat until idle before reading a result. */
`timescale 1ns/1ps
module bbfx_exec_unit_chk
  import bbfx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic acc;
  logic stat_rd;
  logic [4:0] last_op;
  assign acc = psel & penable & ce;
  assign stat_rd = acc & ~pwrite & (paddr == BBFX_STAT_ADDR) & ~prdata[0];
  // ****************************************
  // last command written, accepted or not
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_op <= 5'h00;
    end else if (acc && pwrite && paddr == BBFX_CMD_ADDR && pstrb != 4'h0) begin
      last_op <= pwdata[4:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_ce; pready == ce; endproperty
  a_ready_ce: assert property (p_ready_ce) else $error("pready differs from ce");
  property p_io_cyc; stat_rd && last_op inside {5'h12, 5'h13} |-> prdata[3:2] == 2'h2; endproperty
  a_io_cyc: assert property (p_io_cyc) else $error("io bit op not two cycles");
  property p_shift_cyc; stat_rd && last_op inside {[5'h14:5'h17]} |-> prdata[3:2] == 2'h1; endproperty
  a_shift_cyc: assert property (p_shift_cyc) else $error("shift not one cycle");
  property p_flag_cyc; stat_rd && last_op inside {5'h19, 5'h1a, 5'h1d, 5'h1e} |-> prdata[3:2] == 2'h1; endproperty
  a_flag_cyc: assert property (p_flag_cyc) else $error("flag op not one cycle");
  property p_bit_cyc; stat_rd && last_op inside {5'h1b, 5'h1c, 5'h1f} |-> prdata[3:2] == 2'h1; endproperty
  a_bit_cyc: assert property (p_bit_cyc) else $error("bit or copy op not one cycle");
  property p_br_cyc; stat_rd && last_op inside {[5'h01:5'h11]} |-> prdata[3:2] == (prdata[1] ? 2'h2 : 2'h1); endproperty
  a_br_cyc: assert property (p_br_cyc) else $error("branch cycle count wrong");
  property p_err_map; psel && penable && paddr inside {[12'h000:12'h00c]} && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("error on mapped address");
  property p_err_unmap; psel && penable && pready && paddr >= 12'h180 |-> pslverr && prdata == 32'h0; endproperty
  a_err_unmap: assert property (p_err_unmap) else $error("no error on unmapped address");
  property p_rd_hold; psel && penable && !pready |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved in stall");
  c_taken: cover property (stat_rd && prdata[1]);
  c_io: cover property (stat_rd && last_op == 5'h12);
  c_err: cover property (acc && pslverr);
  c_stall: cover property (psel && penable && !ce);
endmodule : bbfx_exec_unit_chk

bind bbfx_exec_unit bbfx_exec_unit_chk i_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// *** bbfx_pkg.sv ***
/*
 * bbfx_pkg: constants, opcodes and register map of the branch, bit and flag execution unit.
 * assumes: one 125 MHz core clock, apb register access with 32-bit data.
 */
package bbfx_pkg;

  // ****************************************
  // apb register map (byte addresses)
  // ****************************************
  localparam logic [11:0] BBFX_CMD_ADDR = 12'h000;
  localparam logic [11:0] BBFX_PC_ADDR = 12'h004;
  localparam logic [11:0] BBFX_STATUS_FLAGS_REGISTER_ADDR = 12'h008;
  localparam logic [11:0] BBFX_STAT_ADDR = 12'h00c;
  localparam logic [4:0] BBFX_GPR_PAGE = 5'h01;
  localparam logic [4:0] BBFX_IO_PAGE = 5'h02;

  // ****************************************
  // command word fields
  // ****************************************
  localparam int BBFX_OP_LSB = 0;
  localparam int BBFX_RD_LSB = 5;
  localparam int BBFX_RR_LSB = 10;
  localparam int BBFX_BIT_LSB = 15;
  localparam int BBFX_K_LSB = 18;

  // ****************************************
  // status flag positions and reset values
  // ****************************************
  localparam int BBFX_FC = 0;
  localparam int BBFX_FZ = 1;
  localparam int BBFX_FN = 2;
  localparam int BBFX_FV = 3;
  localparam int BBFX_FS = 4;
  localparam int BBFX_FH = 5;
  localparam int BBFX_FT = 6;
  localparam int BBFX_FI = 7;
  localparam logic [7:0] BBFX_STATUS_FLAGS_REGISTER_RST = 8'h00;
  localparam logic [15:0] BBFX_PC_RST = 16'h0000;
  localparam logic [7:0] BBFX_REG_RST = 8'h00;

  // ****************************************
  // cycle counts
  // ****************************************
  localparam int BBFX_BRANCH_TAKEN_CYC = 2;
  localparam int BBFX_IO_BIT_CYC = 2;
  localparam int BBFX_SINGLE_CYC = 1;

  typedef enum logic [4:0] {
    BBFX_OP_NOP = 5'h00,
    BBFX_OP_BRANCH_ZERO_CLEAR = 5'h01,
    BBFX_OP_BRANCH_CARRY_ONE = 5'h02,
    BBFX_OP_BRANCH_CARRY_ZERO = 5'h03,
    BBFX_OP_BRANCH_UNSIGNED_GE = 5'h04,
    BBFX_OP_BRANCH_UNSIGNED_LT = 5'h05,
    BBFX_OP_BRANCH_NEGATIVE = 5'h06,
    BBFX_OP_BRANCH_NONNEGATIVE = 5'h07,
    BBFX_OP_BRANCH_SIGNED_GE = 5'h08,
    BBFX_OP_BRANCH_SIGNED_LT = 5'h09,
    BBFX_OP_BRANCH_HALFCARRY_ONE = 5'h0a,
    BBFX_OP_BRANCH_HALFCARRY_ZERO = 5'h0b,
    BBFX_OP_BRANCH_TBIT_ONE = 5'h0c,
    BBFX_OP_BRANCH_TBIT_ZERO = 5'h0d,
    BBFX_OP_BRANCH_OVERFLOW_ONE = 5'h0e,
    BBFX_OP_BRANCH_OVERFLOW_ZERO = 5'h0f,
    BBFX_OP_BRANCH_IRQ_ON = 5'h10,
    BBFX_OP_BRANCH_IRQ_OFF = 5'h11,
    BBFX_OP_IO_BIT_FORCE_HIGH = 5'h12,
    BBFX_OP_IO_BIT_FORCE_LOW = 5'h13,
    BBFX_OP_SHIFT_UP_LOGICAL = 5'h14,
    BBFX_OP_SHIFT_DOWN_LOGICAL = 5'h15,
    BBFX_OP_ROTATE_DOWN_VIA_CARRY = 5'h16,
    BBFX_OP_SHIFT_DOWN_ARITH = 5'h17,
    BBFX_OP_NIBBLE_SWAP = 5'h18,
    BBFX_OP_FLAG_FORCE_HIGH_INDEXED = 5'h19,
    BBFX_OP_FLAG_FORCE_LOW_INDEXED = 5'h1a,
    BBFX_OP_BIT_TO_TRANSFER_FLAG = 5'h1b,
    BBFX_OP_TRANSFER_FLAG_TO_BIT = 5'h1c,
    BBFX_OP_INTERRUPTS_ON = 5'h1d,
    BBFX_OP_INTERRUPTS_OFF = 5'h1e,
    BBFX_OP_REGISTER_COPY = 5'h1f
  } bbfx_op_t;

  typedef enum logic [1:0] {
    BBFX_ST_IDLE = 2'b00,
    BBFX_ST_EXEC = 2'b01,
    BBFX_ST_EXEC2 = 2'b11
  } bbfx_state_t;

endpackage : bbfx_pkg

// *** tb.sv ***
/* tb: self-checking bench for bbfx_exec_unit over apb.
   assumes: apb slave that stalls while ce is low, stat polled until idle. */
`timescale 1ns/1ps
module tb
  import bbfx_pkg::*;
;
  localparam logic [11:0] G3 = 12'h08c;
  localparam logic [11:0] G4 = 12'h090;
  localparam logic [11:0] G6 = 12'h098;
  localparam logic [11:0] G7 = 12'h09c;
  localparam logic [11:0] G9 = 12'h0a4;
  localparam logic [11:0] IO5 = 12'h114;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rdat;
  logic rerr;
  int n_mismatch = 0;
  int compares = 0;
  always #4 pclk = ~pclk;
  bbfx_exec_unit i_bbfx_exec_unit (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ****************************************
  // bus and compare helpers
  // ****************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr
  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rdat, e);
  endtask : rchk
  function automatic logic [31:0] mk(input logic [4:0] op, input logic [4:0] rd, input logic [4:0] rr,
    input logic [2:0] b, input logic [6:0] k);
    return {7'h00, k, b, rr, rd, op};
  endfunction : mk
  // issue a command, poll until idle, check its cycle count
  task exec(input logic [31:0] cmd, input logic [1:0] cyc);
    int n;
    n = 0;
    wr(BBFX_CMD_ADDR, cmd);
    do begin
      apb(1'b0, BBFX_STAT_ADDR, 32'h0, 4'hf);
      n++;
    end while (rdat[0] !== 1'b0 && n < 20);
    chk({31'h0, rdat[0]}, 32'h0);
    chk({30'h0, rdat[3:2]}, {30'h0, cyc});
  endtask : exec
  function automatic logic cond(input logic [4:0] op, input logic [7:0] f);
    case (op)
      5'h01: return !f[1];
      5'h02, 5'h05: return f[0];
      5'h03, 5'h04: return !f[0];
      5'h06: return f[2];
      5'h07: return !f[2];
      5'h08: return !(f[2] ^ f[3]);
      5'h09: return f[2] ^ f[3];
      5'h0a: return f[5];
      5'h0b: return !f[5];
      5'h0c: return f[6];
      5'h0d: return !f[6];
      5'h0e: return f[3];
      5'h0f: return !f[3];
      5'h10: return f[7];
      default: return !f[7];
    endcase
  endfunction : cond
  // ****************************************
  // scenarios
  // ****************************************
  task t_bus;
    rchk(BBFX_PC_ADDR, 32'h0);
    rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h0);
    rchk(G3, 32'h0);
    apb(1'b0, 12'h200, 32'h0, 4'hf);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, BBFX_PC_ADDR, 32'h77, 4'h0);
    rchk(BBFX_PC_ADDR, 32'h0);
    ce <= 1'b0;
    fork
      wr(BBFX_PC_ADDR, 32'h33);
    join_none
    repeat (3) @(posedge pclk);
    chk({31'h0, pready}, 32'h0);
    ce <= 1'b1;
    wait fork;
    rchk(BBFX_PC_ADDR, 32'h33);
  endtask : t_bus
  task t_branch;
    logic [7:0] f;
    logic [6:0] k;
    logic t;
    for (int j = 0; j < 3; j++) begin
      for (int op = 1; op < 18; op++) begin
        f = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'h04;
        k = (j == 0) ? 7'h05 : 7'h7d;
        t = cond(5'(op), f);
        wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, {24'h0, f});
        wr(BBFX_PC_ADDR, 32'h40);
        exec(mk(5'(op), 5'h0, 5'h0, 3'h0, k), t ? 2'h2 : 2'h1);
        chk({31'h0, rdat[1]}, {31'h0, t});
        rchk(BBFX_PC_ADDR, t ? {16'h0, 16'h0041 + {{9{k[6]}}, k}} : 32'h41);
        rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, {24'h0, f});
      end
    end
  endtask : t_branch
  task t_io;
    wr(IO5, 32'ha5);
    wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h5a);
    exec(mk(5'h12, 5'h0, 5'h5, 3'h1, 7'h0), 2'h2);
    rchk(IO5, 32'ha7);
    exec(mk(5'h13, 5'h0, 5'h5, 3'h7, 7'h0), 2'h2);
    rchk(IO5, 32'h27);
    rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h5a);
  endtask : t_io
  task t_shift;
    logic [7:0] v;
    logic [7:0] r;
    logic c;
    for (int j = 0; j < 2; j++) begin
      for (int op = 20; op < 24; op++) begin
        v = j ? 8'h01 : 8'h81;
        c = (op == 20) ? v[7] : v[0];
        case (op)
          20: r = {v[6:0], 1'b0};
          21: r = {1'b0, v[7:1]};
          22: r = {1'b1, v[7:1]};
          default: r = {v[7], v[7:1]};
        endcase
        wr(G3, {24'h0, v});
        wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'hf1);
        exec(mk(5'(op), 5'h3, 5'h0, 3'h0, 7'h0), 2'h1);
        rchk(G3, {24'h0, r});
        rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, {24'h0, 4'hf, r[7] ^ c, r[7], r == 8'h00, c});
      end
    end
  endtask : t_shift
  task t_flag;
    for (int s = 0; s < 8; s++) begin
      wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h0);
      exec(mk(5'h19, 5'h0, 5'h0, 3'(s), 7'h0), 2'h1);
      rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h1 << s);
      wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'hff);
      exec(mk(5'h1a, 5'h0, 5'h0, 3'(s), 7'h0), 2'h1);
      rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'hff ^ (32'h1 << s));
    end
    wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h0);
    exec(mk(5'h1d, 5'h0, 5'h0, 3'h0, 7'h0), 2'h1);
    rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h80);
    wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'hff);
    exec(mk(5'h1e, 5'h0, 5'h0, 3'h0, 7'h0), 2'h1);
    rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h7f);
  endtask : t_flag
  task t_bit;
    wr(G4, 32'h20);
    wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h0);
    exec(mk(5'h1b, 5'h0, 5'h4, 3'h5, 7'h0), 2'h1);
    rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h40);
    wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'hff);
    exec(mk(5'h1b, 5'h0, 5'h4, 3'h4, 7'h0), 2'h1);
    rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'hbf);
    wr(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h40);
    exec(mk(5'h1c, 5'h6, 5'h0, 3'h3, 7'h0), 2'h1);
    rchk(G6, 32'h08);
    wr(G7, 32'h5a);
    wr(BBFX_PC_ADDR, 32'h0123);
    exec(mk(5'h1f, 5'h9, 5'h7, 3'h0, 7'h0), 2'h1);
    rchk(G9, 32'h5a);
    exec(mk(5'h18, 5'h9, 5'h0, 3'h0, 7'h0), 2'h1);
    rchk(G9, 32'ha5);
    rchk(BBFX_STATUS_FLAGS_REGISTER_ADDR, 32'h40);
    rchk(BBFX_PC_ADDR, 32'h0125);
  endtask : t_bit
  task end_sim;
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bus;
    t_branch;
    t_io;
    t_shift;
    t_flag;
    t_bit;
    end_sim;
  end
endmodule : tb
